// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tla_pkg::*;
  localparam int CL = 16;
  logic sys_clk = 0, reset = 1, wr = 0, rd = 0, hot_req = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  tla_byte_t t [3] = '{8'h00, 8'h00, 8'h00};
  logic pin, out, oe, hot, irq, pull;
  int error_cnt = 0, check_count = 0;
  always #20 sys_clk = ~sys_clk;
  // Pulled-up line, low while either party pulls
  assign pin = !(oe | pull);
  tla_alarm #(.CYCLE_LEN(CL)) i_dut (.sys_clk(sys_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .temp_r1(t[0]), .temp_loc(t[1]),
    .temp_r2(t[2]), .thermal_alarm_pin_in(pin), .thermal_alarm_pin_out(out),
    .thermal_alarm_pin_oe(oe), .processor_hot_signal(hot), .irq(irq));
  tla_cpu_model i_cpu (.sys_clk(sys_clk), .hot_req(hot_req), .pull(pull));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic set_t(input int c, input logic [7:0] v);
    @(posedge sys_clk);
    t[c] <= v;
  endtask
  // Two full monitoring cycles, then the drive level
  task automatic settle(input logic e);
    repeat (2 * CL + 4) @(posedge sys_clk);
    #1 chk({7'h00, oe}, {7'h00, e});
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    logic [7:0] lim;
    void'($urandom(32'h66de));
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int a = 0; a < 3; a++) rreg(8'h6a + 8'(a), 8'h7f);
    rreg(8'h50, 8'h00);
    wreg(8'h7d, 8'h01);
    wreg(8'h78, 8'h02);
    wreg(8'h7c, 8'he0);
    rreg(8'h7c, 8'he0);
    for (int ch = 0; ch < 3; ch++) begin
      lim = 8'($urandom_range(16, 95));
      wreg(8'h6a + 8'(ch), lim);
      rreg(8'h6a + 8'(ch), lim);
      set_t(ch, lim);
      settle(1'b0);
      wreg(8'h7c, 8'he0 ^ (8'h20 << ch));
      set_t(ch, lim + 8'h01);
      settle(1'b0);
      wreg(8'h7c, 8'he0);
      settle(1'b1);
      settle(1'b1);
      rreg(8'h95, 8'h07);
      rreg(8'h92 + 8'(ch), lim + 8'h01);
      set_t(ch, lim);
      settle(1'b0);
    end
    wreg(8'h78, 8'h00);
    set_t(2, lim + 8'h01);
    settle(1'b0);
    wreg(8'h7d, 8'h02);
    wreg(8'h78, 8'h02);
    settle(1'b0);
    wreg(8'h6c, 8'h80);
    wreg(8'h7d, 8'h01);
    settle(1'b0);
    wreg(8'h96, 8'h01);
    wreg(8'h6c, 8'h00);
    settle(1'b0);
    hot_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk({6'h00, hot, irq}, 8'h02);
    wreg(8'h91, 8'hf7);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h00, irq}, 8'h01);
    @(posedge sys_clk);
    hot_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wreg(8'h90, 8'h08);
    repeat (2) @(posedge sys_clk);
    #1 chk({6'h00, hot, irq}, 8'h00);
    rreg(8'h90, 8'h07);
    end_of_test();
  end
endmodule // testbench
bind tla_alarm tla_alarm_asserts #(.CYCLE_LEN(CYCLE_LEN)) i_chk (.sys_clk(sys_clk),
  .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .thermal_alarm_pin_in(thermal_alarm_pin_in), .thermal_alarm_pin_out(thermal_alarm_pin_out),
  .thermal_alarm_pin_oe(thermal_alarm_pin_oe), .processor_hot_signal(processor_hot_signal),
  .irq(irq));
`default_nettype wire

// file: tla_alarm.sv
// Behaviour
// RULE1: The block can pull the shared alarm pin low and also senses its level.
// RULE2: A channel whose temperature exceeds its limit, while enabled, asserts the alarm low.
// RULE3: An alarm still over limit at the next monitoring cycle stays asserted without a gap.
// RULE4: The alarm is released only after a measurement at or below the limit; the code also releases it when the channel or pin function is disabled.
// RULE5: Channels are evaluated once per monitoring cycle so an alarm lasts at least one cycle.
// RULE6: Separate limits for remote 1, local and remote 2 sit at 0x6a, 0x6b, 0x6c.
// RULE7: Bits 5, 6, 7 of config five enable the alarm for remote 1, local and remote 2.
// RULE8: A limit at or below -64 C (offset-64) or -128 C (twos complement) disables the channel.
// RULE9: Clearing bit 1 of config three disables the alarm pin function entirely.
// RULE10: The pin drive is the OR of enabled over-limit channels as an open-drain pull-down.
// RULE11: The alarm reaches the pin only when the function select in config four is 01.
// RULE12: An external low while the block is not pulling counts as an alarm assertion.
//
// Strobed register access is this design's own decision.
`include "tla_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tla_alarm
  import tla_pkg::*;
#(
  parameter int CYCLE_LEN = `TLA_CYCLE_LEN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Measured temperatures, updated by the converter
  input wire logic [7:0] temp_r1,
  input wire logic [7:0] temp_loc,
  input wire logic [7:0] temp_r2,
  // Shared alarm pin, open drain
  input wire logic thermal_alarm_pin_in,
  output logic thermal_alarm_pin_out,
  output logic thermal_alarm_pin_oe,
  // Alarm line seen low, by any party including this block, and interrupt
  output logic processor_hot_signal,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  // Unsigned comparison value, twos complement mapped onto an offset frame, offset-64 kept as is
  function automatic logic [8:0] tla_val(input logic [7:0] v, input logic fmt64);
    tla_val = fmt64 ? {1'b0, v} : {~v[7], v};
  endfunction

  function automatic logic tla_lim_dis(input logic [7:0] lim, input logic fmt64);
    tla_lim_dis = fmt64 ? (lim <= `TLA_OFF64_DIS) : (lim == `TLA_TWOS_DIS);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] lim [3];
  logic [7:0] cfg3;
  logic [7:0] cfg4;
  logic [7:0] cfg5;
  logic [7:0] cfg_fmt;
  logic [7:0] status;
  logic [7:0] mask;
  logic [2:0] over;
  logic [31:0] cyc_cnt;
  logic tick;
  logic ext_prev;
  tla_state_t state;
  logic [7:0] temps [3];
  logic fmt64;
  logic pin_alarm_en;
  logic [2:0] chan_en;
  logic [2:0] chan_hit;
  logic ext_low;
  logic [7:0] events;

  assign temps[0] = temp_r1;
  assign temps[1] = temp_loc;
  assign temps[2] = temp_r2;
  assign fmt64 = cfg_fmt[`TLA_FMT_BIT];
  assign pin_alarm_en = cfg3[`TLA_CFG3_EN_BIT]
    && (cfg4[`TLA_CFG4_FUNC_LSB +: 2] == `TLA_FUNC_ALARM); // RULE9 RULE11

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lim[0] <= `TLA_LIM_RST;
      lim[1] <= `TLA_LIM_RST;
      lim[2] <= `TLA_LIM_RST;
      cfg3 <= `TLA_CFG3_RST;
      cfg4 <= `TLA_CFG4_RST;
      cfg5 <= `TLA_CFG5_RST;
      cfg_fmt <= `TLA_CFG_FMT_RST;
      mask <= 8'hff;
    end else if (wr) begin
      case (addr)
        `TLA_OFF_LIM_R1: lim[0] <= wdata; // RULE6
        `TLA_OFF_LIM_LOC: lim[1] <= wdata; // RULE6
        `TLA_OFF_LIM_R2: lim[2] <= wdata; // RULE6
        `TLA_OFF_CFG3: cfg3 <= wdata;
        `TLA_OFF_CFG4: cfg4 <= wdata;
        `TLA_OFF_CFG5: cfg5 <= wdata;
        `TLA_OFF_FMT: cfg_fmt <= wdata;
        `TLA_OFF_MASK: mask <= wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Monitoring cycle
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cyc_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (cyc_cnt == CYCLE_LEN - 1) begin
      cyc_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      cyc_cnt <= cyc_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      chan_en[i] = cfg5[`TLA_CFG5_EN_LSB + i] && !tla_lim_dis(lim[i], fmt64); // RULE7 RULE8
      chan_hit[i] = tla_val(temps[i], fmt64) > tla_val(lim[i], fmt64); // RULE2 RULE4
    end
  end

  // Over flags change only in the evaluation state after a tick, so each alarm holds a whole cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      over <= 3'h0;
      state <= tla_idle_t_s;
    end else begin
      case (state)
        tla_idle_t_s: if (tick) state <= tla_eval_s; // RULE5
        tla_eval_s: begin
          // Pin enable is sampled here too, so the drive only moves at an evaluation
          over <= chan_hit & chan_en & {3{pin_alarm_en}}; // RULE3 RULE4 RULE9 RULE11
          state <= tla_idle_t_s;
        end
        default: state <= tla_idle_t_s;
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      thermal_alarm_pin_out <= 1'b0;
      thermal_alarm_pin_oe <= 1'b0;
    end else begin
      thermal_alarm_pin_out <= 1'b0; // RULE10
      thermal_alarm_pin_oe <= |over; // RULE1 RULE2 RULE10
    end
  end

  assign ext_low = pin_alarm_en && !thermal_alarm_pin_in && !thermal_alarm_pin_oe; // RULE12

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      processor_hot_signal <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      processor_hot_signal <= pin_alarm_en && !thermal_alarm_pin_in; // RULE1 RULE12
      ext_prev <= ext_low;
    end
  end

  // ****************************************
  // Status, interrupt and read port
  // ****************************************
  assign events = {4'h0, ext_low && !ext_prev, over & chan_en};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status <= 8'h00;
    end else if (wr && addr == `TLA_OFF_STATUS) begin
      status <= (status & ~wdata) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & ~mask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `TLA_OFF_LIM_R1: rdata <= lim[0];
        `TLA_OFF_LIM_LOC: rdata <= lim[1];
        `TLA_OFF_LIM_R2: rdata <= lim[2];
        `TLA_OFF_CFG3: rdata <= cfg3;
        `TLA_OFF_CFG4: rdata <= cfg4;
        `TLA_OFF_CFG5: rdata <= cfg5;
        `TLA_OFF_FMT: rdata <= cfg_fmt;
        `TLA_OFF_STATUS: rdata <= status;
        `TLA_OFF_MASK: rdata <= mask;
        `TLA_OFF_TEMP_R1: rdata <= temp_r1;
        `TLA_OFF_TEMP_LOC: rdata <= temp_loc;
        `TLA_OFF_TEMP_R2: rdata <= temp_r2;
        `TLA_OFF_PIN: rdata <= {5'h0, thermal_alarm_pin_oe, processor_hot_signal, |over};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // tla_alarm
`default_nettype wire

// file: tla_alarm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tla_alarm_asserts #(
  parameter int CYCLE_LEN = 4096
) (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Alarm line and status
  input wire logic thermal_alarm_pin_in,
  input wire logic thermal_alarm_pin_out,
  input wire logic thermal_alarm_pin_oe,
  input wire logic processor_hot_signal,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  int hi_cnt;
  int lo_cnt;
  logic en_seen;
  // Length of the present drive level, and whether any channel was enabled
  always_ff @(posedge sys_clk) begin
    hi_cnt <= (reset || !thermal_alarm_pin_oe) ? 0 : hi_cnt + 1;
    lo_cnt <= (reset || thermal_alarm_pin_oe) ? 0 : lo_cnt + 1;
    en_seen <= !reset && (en_seen || (wr && addr == 8'h7c && wdata[7:5] != 3'h0));
  end
  a_out_low: assert property (!thermal_alarm_pin_out)
    else $error("alarm pin driven high");
  a_oe_min_hold: assert property (!$past(reset) && $fell(thermal_alarm_pin_oe)
    |-> hi_cnt >= CYCLE_LEN) else $error("alarm released too early");
  a_oe_rise_gap: assert property ($rose(thermal_alarm_pin_oe) |-> lo_cnt >= CYCLE_LEN - 1)
    else $error("alarm asserted between evaluations");
  a_alarm_needs_enable: assert property ($rose(thermal_alarm_pin_oe) |-> en_seen)
    else $error("alarm without an enabled channel");
  a_hot_clear: assert property (thermal_alarm_pin_in [*3] |-> !processor_hot_signal)
    else $error("hot flag with line high");
  a_hot_rise: assert property ($rose(processor_hot_signal)
    |-> !$past(thermal_alarm_pin_in) || !$past(thermal_alarm_pin_in, 2))
    else $error("hot flag without line low");
  a_rdata_idle: assert property (rdata != 8'h00 |-> $past(rd))
    else $error("read data outside read slot");
  a_reset_quiet: assert property ($past(reset) |-> !thermal_alarm_pin_oe && !irq
    && !processor_hot_signal && rdata == 8'h00) else $error("outputs not cleared by reset");
endmodule // tla_alarm_asserts
`default_nettype wire

// file: tla_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tla_cpu_model (
  // Clock and throttle request
  input wire logic sys_clk,
  input wire logic hot_req,
  // Open-drain pull on the shared line
  output logic pull
);
  always_ff @(posedge sys_clk) pull <= hot_req;
endmodule // tla_cpu_model
`default_nettype wire

// file: tla_map.svh
`ifndef TLA_MAP_SVH
`define TLA_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define TLA_OFF_LIM_R1 8'h6a
`define TLA_OFF_LIM_LOC 8'h6b
`define TLA_OFF_LIM_R2 8'h6c
`define TLA_OFF_CFG3 8'h78
`define TLA_OFF_CFG4 8'h7d
`define TLA_OFF_CFG5 8'h7c
`define TLA_OFF_STATUS 8'h90
`define TLA_OFF_MASK 8'h91
`define TLA_OFF_TEMP_R1 8'h92
`define TLA_OFF_TEMP_LOC 8'h93
`define TLA_OFF_TEMP_R2 8'h94
`define TLA_OFF_PIN 8'h95
// ****************************************
// Fields and reset values
// ****************************************
`define TLA_CFG3_EN_BIT 1
`define TLA_CFG5_EN_LSB 5
`define TLA_CFG4_FUNC_LSB 0
`define TLA_FUNC_ALARM 2'h1
`define TLA_CFG3_RST 8'h00
`define TLA_CFG4_RST 8'h00
`define TLA_CFG5_RST 8'h00
`define TLA_LIM_RST 8'h7f
`define TLA_OFF64_DIS 8'h00
`define TLA_TWOS_DIS 8'h80
`define TLA_FMT_BIT 0
`define TLA_CFG_FMT_RST 8'h00
`define TLA_OFF_FMT 8'h96
// Monitoring cycle length in sys_clk cycles
`define TLA_CYCLE_LEN 32'd4096
`endif

// file: tla_pkg.sv
package tla_pkg;
  typedef enum logic [1:0] {tla_idle_t_s, tla_eval_s} tla_state_t;
  typedef logic [7:0] tla_byte_t;
endpackage
